// File: hdl/flow_ctrl_defs.svh
// register offsets, field positions and reset values of the conversion flow control
`ifndef FLOW_CTRL_DEFS_SVH
`define FLOW_CTRL_DEFS_SVH
`define ADDR_W        4
`define OFS_CTRL      4'h0
`define OFS_FLOW      4'h4
`define OFS_STATUS    4'h8
`define CTRL_MODE     0
`define CTRL_ACC_LO   1
`define CTRL_ACC_HI   2
`define FLOW_RESTART  0
`define FLOW_TRIGGER  1
`define FLOW_ABORT    2
`define FLOW_LOAD_OK  3
`define ST_TERR       0
`define ST_FAIL       1
`define ST_LIST       2
`define ST_RUN        3
`define ST_STATE_LO   4
`define ST_STATE_HI   7
`define ST_IDX_LO     8
`define MODE_RST      1'h0
`define ACC_RST       2'h1
`define ACC_REG       0
`define ACC_INT       1
`endif

// File: hdl/flow_pkg.sv
// types shared by the conversion flow control
package flow_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_LOADED = 4'h2,
    ST_RUN    = 4'h4,
    ST_HALT   = 4'h8
  } flow_state_t;
  typedef struct packed {
    logic load_ok;
    logic abort;
    logic trigger;
    logic restart;
  } flow_req_t;
endpackage

// File: hdl/adc_flow_ctrl.sv
// conversion flow control: request decode, list walk, double-buffer swap
//
// Operation
// - four requests from register or internal path
// - trigger mode and restart mode selectable
// - trigger mode: restart also raises trigger
// - trigger mode: restart with trigger halts
// - trigger mode: list wraps, triggers only
// - restart mode: both together set error
// - restart loads first command of list
// - restart with load-ok swaps lists first
// - trigger starts sequence at loaded command
// - abort stops conversion, sequence and list; with a restart it stops conversion and reloads the list
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "flow_ctrl_defs.svh"
module adc_flow_ctrl #(
  parameter int IDX_W = 6
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [3:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire flow_pkg::flow_req_t int_req,
  input  wire logic              cmd_done,
  input  wire logic              cmd_end_of_list,
  output logic                   conv_start,
  output logic                   conv_abort,
  output logic                   list_load,
  output logic                   active_list,
  output logic      [IDX_W-1:0]  cmd_index,
  output logic                   seq_running,
  output logic                   trigger_error_flag,
  output logic                   flow_failure
);
  import flow_pkg::*;

  flow_state_t       state;
  flow_state_t       next_state;
  flow_req_t         req;
  logic              trigger_request_mode;
  logic [1:0]        flow_access_select;
  logic [IDX_W-1:0]  next_index;
  logic              next_start;

  // register decode
  wire wr_ctrl   = wr && (addr == `OFS_CTRL);
  wire wr_flow   = wr && (addr == `OFS_FLOW);
  wire wr_status = wr && (addr == `OFS_STATUS);
  wire terr_clr  = wr_status && wdata[`ST_TERR];
  wire fail_clr  = wr_status && wdata[`ST_FAIL];

  // each source gated by the access select
  wire       reg_en = flow_access_select[`ACC_REG];
  wire       int_en = flow_access_select[`ACC_INT];
  flow_req_t                    reg_req;
  logic [$bits(flow_req_t)-1:0] reg_bits;
  // one gate per request bit; the struct keeps restart lowest, so the
  // flow register bits map straight across from the restart position up
  for (genvar b = 0; b < $bits(flow_req_t); b++) begin : g_reg_req
    assign reg_bits[b] = wr_flow && reg_en && wdata[`FLOW_RESTART + b];
  end
  assign reg_req = flow_req_t'(reg_bits);
  wire flow_req_t int_gated = int_en ? int_req : '0;

  // both paths land in one flop so they are judged in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      req <= '0;
    end else begin
      req <= reg_req | int_gated;
    end
  end

  // mode and access configuration
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      trigger_request_mode          <= `MODE_RST;
      flow_access_select <= `ACC_RST;
    end else if (wr_ctrl) begin
      trigger_request_mode          <= wdata[`CTRL_MODE];
      flow_access_select <= wdata[`CTRL_ACC_HI:`CTRL_ACC_LO];
    end
  end

  // request classification
  // a refused pair must not start anything, hence ok gates every action
  wire halted    = (state == ST_HALT);
  wire raw_both  = req.restart && req.trigger;
  wire fail_evt  = trigger_request_mode && raw_both && !halted;
  wire terr_evt  = !trigger_request_mode && raw_both;
  wire ok        = !raw_both && !halted;
  wire do_abort  = ok && req.abort;
  wire do_rst    = ok && req.restart;
  wire do_trigger_request   = ok && (req.trigger || (trigger_request_mode && req.restart));
  wire do_swap   = do_rst && req.load_ok;

  // next state of the list walk
  always_comb begin
    next_state = state;
    next_index = cmd_index;
    next_start = 1'h0;
    unique case (state)
      ST_HALT: begin
        if (fail_clr) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE, ST_LOADED, ST_RUN: begin
        if (fail_evt) begin
          next_state = ST_HALT;
        end else begin
          if (do_abort) begin
            next_state = ST_IDLE;
          end
          if (do_rst) begin
            next_index = '0;
            next_state = do_trigger_request ? ST_RUN : ST_LOADED;
            next_start = do_trigger_request;
          end else if (do_trigger_request && !do_abort && state == ST_LOADED) begin
            next_state = ST_RUN;
            next_start = 1'h1;
          end else if (state == ST_RUN && cmd_done && !do_abort) begin
            if (cmd_end_of_list) begin
              next_index = '0;
              // restart mode waits for a fresh restart before triggers count
              next_state = trigger_request_mode ? ST_LOADED : ST_IDLE;
            end else begin
              next_index = IDX_W'(cmd_index + 1'h1);
            end
          end
        end
      end
    endcase
  end

  // walk state and output pulses
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state      <= ST_IDLE;
      cmd_index  <= '0;
      conv_start <= 1'h0;
      conv_abort <= 1'h0;
      list_load  <= 1'h0;
    end else begin
      state      <= next_state;
      cmd_index  <= next_index;
      conv_start <= next_start;
      conv_abort <= do_abort || fail_evt;
      list_load  <= do_rst && !fail_evt;
    end
  end

  // double buffer select flips before the top command is loaded
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      active_list <= 1'h0;
    end else if (do_swap) begin
      active_list <= !active_list;
    end
  end

  // error flag: a new error beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      trigger_error_flag <= 1'h0;
    end else begin
      trigger_error_flag <= terr_evt || (trigger_error_flag && !terr_clr);
    end
  end

  // status levels come straight from the walk state, no extra delay
  assign seq_running  = (state == ST_RUN);
  assign flow_failure = halted;

  // read mux; flow register is write-only and reads zero
  wire [31:0] ctrl_rd = {29'h0, flow_access_select, trigger_request_mode};
  wire [31:0] stat_rd = {{(24-IDX_W){1'h0}}, cmd_index, state, seq_running,
                         active_list, flow_failure, trigger_error_flag};
  wire [31:0] rd_mux  = (addr == `OFS_CTRL)   ? ctrl_rd :
                        (addr == `OFS_STATUS) ? stat_rd : 32'h0;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? rd_mux : 32'h0;
    end
  end

  // checks; requests are taken one edge after the strobe, so most
  // properties look at the registered request and judge the edge after.
  // the error flag and the failure state are sticky on purpose: software
  // must still see them after a later request is accepted cleanly.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_started;
    conv_start && state == ST_RUN;
  endsequence

  a_trigger_request_auto: assert property (
    trigger_request_mode && ok && req.restart |=> s_started)
    else $error("restart in trigger mode did not start");

  a_fail_halt: assert property (
    fail_evt |=> flow_failure && conv_abort ##1 !conv_start)
    else $error("restart with trigger did not halt");

  a_halt_hold: assert property (
    halted && !fail_clr |=> halted && !conv_start)
    else $error("halt left without clear");

  a_eol_wrap: assert property (
    trigger_request_mode && state == ST_RUN && cmd_done && cmd_end_of_list && !req.restart
    && !req.abort && !req.trigger |=> state == ST_LOADED && cmd_index == '0)
    else $error("trigger mode list did not wrap");

  a_terr_set: assert property (
    terr_evt && !halted |=> trigger_error_flag && !conv_start && ($stable(state) || $past(cmd_done)))
    else $error("restart mode error not flagged");

  a_restart_top: assert property (
    do_rst |=> cmd_index == '0 && list_load)
    else $error("restart did not load list top");

  a_list_swap: assert property (
    do_swap |=> active_list != $past(active_list))
    else $error("load-ok restart did not swap lists");

  a_trigger_request_start: assert property (
    ok && req.trigger && !req.restart && !req.abort && state == ST_LOADED
    |=> s_started)
    else $error("trigger did not start sequence");

  a_abort_stop: assert property (
    do_abort && !do_rst |=> conv_abort && state == ST_IDLE)
    else $error("abort did not stop list");

  a_int_align: assert property (
    int_en && int_req.trigger |=> req.trigger)
    else $error("internal trigger lost");

  // a refused trigger must leave conv_start and list_load low and the walk idle
  sequence s_idle_quiet;
    !conv_start && !list_load && state == ST_IDLE;
  endsequence

  sequence s_top_idle;
    state == ST_IDLE && cmd_index == '0;
  endsequence

  a_idx_step: assert property (
    state == ST_RUN && cmd_done && !cmd_end_of_list && !do_abort && !do_rst && !fail_evt
    |=> cmd_index == IDX_W'($past(cmd_index) + 1'h1))
    else $error("command index did not advance");

  a_rst_eol: assert property (
    !trigger_request_mode && state == ST_RUN && cmd_done && cmd_end_of_list && !req.restart && !req.abort
    |=> s_top_idle)
    else $error("restart mode list did not stop at end");

  a_idle_trigger_request: assert property (
    state == ST_IDLE && req.trigger && !req.restart |=> s_idle_quiet)
    else $error("trigger started without restart");

  a_halt_quiet: assert property (
    halted |=> !list_load && !conv_abort && $stable(active_list))
    else $error("halted block still acted");

  a_terr_hold: assert property (
    trigger_error_flag && !terr_clr |=> trigger_error_flag)
    else $error("error flag lost without clear");

  a_reg_gate: assert property (
    wr_flow && !reg_en && wdata[`FLOW_RESTART] && !(int_en && int_req.restart) |=> !req.restart)
    else $error("register request taken while path closed");

  a_int_gate: assert property (
    !int_en && !wr_flow |=> req == '0)
    else $error("internal request taken while path closed");

  a_abort_load: assert property (
    do_abort && do_rst |=> conv_abort && list_load && cmd_index == '0)
    else $error("abort with restart did not reload");

  a_run_trigger_request: assert property (
    state == ST_RUN && req.trigger && !req.restart |=> !conv_start)
    else $error("trigger restarted a running sequence");

  a_rst_load: assert property (
    !trigger_request_mode && do_rst |=> state == ST_LOADED && !conv_start)
    else $error("restart mode restart did not just load");

  a_start_run: assert property (
    conv_start |-> seq_running)
    else $error("start pulse outside running state");

  a_swap_only: assert property (
    !do_swap |=> $stable(active_list))
    else $error("list select moved without swap");
endmodule

// File: tb/conv_model.sv
// converter model: finishes commands while the sequence runs, flags the last of the list
`timescale 1ns/1ps
module conv_model #(
  parameter int LEN = 3
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       seq_running,
  input  wire logic [2:0] lat,
  output logic            cmd_done,
  output logic            cmd_end_of_list
);
  int wait_c;
  int n;
  // end-of-list is only meaningful beside cmd_done, so it toggles otherwise
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_c          <= 0;
      n               <= 0;
      cmd_done        <= 1'b0;
      cmd_end_of_list <= 1'b0;
    end else begin
      cmd_done        <= 1'b0;
      cmd_end_of_list <= ~cmd_end_of_list;
      if (seq_running !== 1'b1) begin
        wait_c <= 0;
        n      <= 0;
      end else if (wait_c == int'(lat)) begin
        cmd_done        <= 1'b1;
        cmd_end_of_list <= (n == LEN - 1);
        wait_c          <= 0;
        n               <= (n == LEN - 1) ? 0 : n + 1;
      end else begin
        wait_c <= wait_c + 1;
      end
    end
  end
endmodule

// File: tb/adc_flow_ctrl_bench.sv
// self-checking bench of the conversion flow control
`timescale 1ns/1ps
`include "flow_ctrl_defs.svh"
module adc_flow_ctrl_bench;
  import flow_pkg::*;
  logic        ref_clk = 0, resetn = 1, wr = 0, rd = 0;
  logic [3:0]  addr = 4'h0;
  logic [3:0]  ra;
  logic [31:0] wdata = 32'h0, rdata;
  flow_req_t   int_req = '0;
  logic [2:0]  lat = 3'h0;
  logic        cmd_done, cmd_end_of_list, conv_start, conv_abort, list_load;
  logic        active_list, seq_running, trigger_error_flag, flow_failure;
  logic [5:0]  cmd_index;
  int          error_cnt = 0, num_checks = 0, cyc = 0, st_n = 0, ab_n = 0, ld_n = 0, s0, a0, l0;
  int          seed = 32'h9F39;

  adc_flow_ctrl #(.IDX_W(6)) uut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .int_req(int_req), .cmd_done(cmd_done),
    .cmd_end_of_list(cmd_end_of_list), .conv_start(conv_start), .conv_abort(conv_abort),
    .list_load(list_load), .active_list(active_list), .cmd_index(cmd_index),
    .seq_running(seq_running), .trigger_error_flag(trigger_error_flag), .flow_failure(flow_failure));
  conv_model #(.LEN(3)) peer (.ref_clk(ref_clk), .resetn(resetn), .seq_running(seq_running),
    .lat(lat), .cmd_done(cmd_done), .cmd_end_of_list(cmd_end_of_list));

  initial forever #50 ref_clk = ~ref_clk;

  // pulse tallies, so a missing or doubled pulse shows as a wrong difference
  always @(posedge ref_clk) begin
    st_n <= st_n + conv_start;
    ab_n <= ab_n + conv_abort;
    ld_n <= ld_n + list_load;
    cyc  <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      give_verdict;
    end
  end

  function automatic logic [31:0] st_word(input logic [3:0] st, input logic lst, fail, terr);
    return {24'h0, st, st == 4'h4, lst, fail, terr};
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    #1 chk(rdata, exp);
  endtask
  task automatic int_pulse(input logic [3:0] v);
    @(posedge ref_clk);
    int_req <= flow_req_t'(v);
    @(posedge ref_clk);
    int_req <= '0;
  endtask
  task automatic snap;
    s0 = st_n;
    a0 = ab_n;
    l0 = ld_n;
  endtask
  // requests act one edge after being taken; one more edge lands the tallies, a third is spare
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic run_out;
    for (int i = 0; i < 80 && seq_running !== 1'b0; i++) @(posedge ref_clk);
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    resetn <= 1'h0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    lat    <= 3'($random(seed));
    rd_chk(`OFS_CTRL, 32'h2);
    rd_chk(`OFS_STATUS, st_word(ST_IDLE, 0, 0, 0));
    repeat (8) begin
      ra = 4'($random(seed));
      rd_chk(ra, (ra == `OFS_CTRL) ? 32'h2 : (ra == `OFS_STATUS) ? st_word(ST_IDLE, 0, 0, 0) : 32'h0);
    end
    // internal path is closed after reset
    snap;
    int_pulse(4'h1);
    settle;
    chk(ld_n - l0, 0);
    bus(1, `OFS_CTRL, 32'h6);
    snap;
    bus(1, `OFS_FLOW, 32'h1);
    settle;
    chk(ld_n - l0, 1);
    rd_chk(`OFS_STATUS, st_word(ST_LOADED, 0, 0, 0));
    snap;
    bus(1, `OFS_FLOW, 32'h2);
    settle;
    chk(st_n - s0, 1);
    chk(seq_running, 1);
    run_out;
    rd_chk(`OFS_STATUS, st_word(ST_IDLE, 0, 0, 0));
    snap;
    bus(1, `OFS_FLOW, 32'h2);
    settle;
    chk(st_n - s0, 0);
    bus(1, `OFS_FLOW, 32'h3);
    settle;
    rd_chk(`OFS_STATUS, st_word(ST_IDLE, 0, 0, 1));
    bus(1, `OFS_STATUS, 32'h1);
    bus(1, `OFS_FLOW, 32'h9);
    settle;
    rd_chk(`OFS_STATUS, st_word(ST_LOADED, 1, 0, 0));
    lat <= 3'($random(seed));
    bus(1, `OFS_FLOW, 32'h2);
    snap;
    bus(1, `OFS_FLOW, 32'h4);
    settle;
    chk(ab_n - a0, 1);
    chk(seq_running, 0);
    // a one-cycle pulse on the internal path must count like a register write
    snap;
    int_pulse(4'h1);
    settle;
    chk(ld_n - l0, 1);
    snap;
    int_pulse(4'h2);
    settle;
    chk(st_n - s0, 1);
    run_out;
    // register path closed: a restart write must be ignored
    bus(1, `OFS_CTRL, 32'h4);
    snap;
    bus(1, `OFS_FLOW, 32'h1);
    settle;
    chk(ld_n - l0, 0);
    bus(1, `OFS_CTRL, 32'h7);
    lat <= 3'($random(seed));
    snap;
    bus(1, `OFS_FLOW, 32'h1);
    settle;
    chk(st_n - s0, 1);
    run_out;
    rd_chk(`OFS_STATUS, st_word(ST_LOADED, 1, 0, 0));
    snap;
    bus(1, `OFS_FLOW, 32'h2);
    settle;
    chk(st_n - s0, 1);
    snap;
    bus(1, `OFS_FLOW, 32'h3);
    settle;
    chk(flow_failure, 1);
    chk(ab_n - a0, 1);
    bus(1, `OFS_STATUS, 32'h2);
    settle;
    chk(flow_failure, 0);
    give_verdict;
  end
endmodule
